// ### design/gpio_bc_consts.svh
// register offsets, field positions, reset values and widths of the port b/c block
`ifndef GPIO_BC_CONSTS_SVH
`define GPIO_BC_CONSTS_SVH
`define GPIO_PORT_W        8
`define GPIO_ADDR_W        8
`define GPIO_OFF_PIN_B     8'h00
`define GPIO_OFF_LAT_B     8'h04
`define GPIO_OFF_DIR_B     8'h08
`define GPIO_OFF_PIN_C     8'h0C
`define GPIO_OFF_LAT_C     8'h10
`define GPIO_OFF_DIR_C     8'h14
`define GPIO_OFF_IRQ_MAIN  8'h18
`define GPIO_OFF_IRQ_EDGE  8'h1C
`define GPIO_OFF_CTRL      8'h20
`define GPIO_DIR_RST       8'hFF
`define GPIO_LAT_RST       8'h00
`define GPIO_BIT_IRQ_EN    3
`define GPIO_BIT_FLAG      0
`define GPIO_BIT_PULL_N    7
`define GPIO_BIT_PRIO      0
`define GPIO_BIT_LVP       0
`define GPIO_PULL_N_RST    1'b1
`define GPIO_PRIO_RST      1'b1
`define GPIO_CHG_LSB       4
`define GPIO_CHG_W         4
`define GPIO_PGM_BIT       5
`define GPIO_RESP_OKAY     2'b00
`define GPIO_RESP_SLVERR   2'b10
`endif

// ### design/gpio_bc_pkg.sv
// types shared by the port b/c block
package gpio_bc_pkg;
  // register selected by a bus address
  typedef enum {
    SEL_PIN_B, SEL_LAT_B, SEL_DIR_B, SEL_PIN_C, SEL_LAT_C, SEL_DIR_C,
    SEL_IRQ_MAIN, SEL_IRQ_EDGE, SEL_CTRL, SEL_NONE
  } reg_sel_type;
endpackage : gpio_bc_pkg

// ### design/gpio_bc_top.sv
// port b and port c general purpose i/o with change detection, axi4-lite registers
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bc_consts.svh"
// Behaviour
// - port b direction 1 input, 0 drives latch
// - port c uses the same direction rule
// - port b eight bidirectional bits with registers
// - port c eight bidirectional bits with registers
// - port b latch register holds latch, not pins
// - port c latch register holds latch, not pins
// - clearing pull-up bit enables port b pulls on input pins
// - output pins never get a pull-up
// - pull-up disable bit resets to one
// - only upper four input pins detect change
// - compare inputs with snapshot from last port b access
// - ORed mismatches set the change flag
// - change event can wake the device
// - port b access refreshes snapshot, except moves
// - persisting mismatch keeps setting the flag
// - low-voltage programming removes bit 5 function, pull
// - peripheral may override port c direction
// - override never written to direction register
// - flag interrupts only when enabled, chosen priority
// - data register reads pins, writes latch
module gpio_bc_top
  import gpio_bc_pkg::*;
#(
  parameter int W  = `GPIO_PORT_W,
  parameter int AW = `GPIO_ADDR_W
) (
  input  wire logic          clk_sys,       // core clock, 100 MHz
  input  wire logic          rst_n,         // async reset, active low
  input  wire logic [AW-1:0] awaddr,        // write address
  input  wire logic          awvalid,       // write address valid
  output logic               awready,       // write address taken
  input  wire logic [31:0]   wdata,         // write data
  input  wire logic [3:0]    wstrb,         // write byte enables
  input  wire logic          wvalid,        // write data valid
  output logic               wready,        // write data taken
  output logic [1:0]         bresp,         // write response
  output logic               bvalid,        // write response valid
  input  wire logic          bready,        // write response taken
  input  wire logic [AW-1:0] araddr,        // read address
  input  wire logic          arvalid,       // read address valid
  output logic               arready,       // read address taken
  output logic [31:0]        rdata,         // read data
  output logic [1:0]         rresp,         // read response
  output logic               rvalid,        // read data valid
  input  wire logic          rready,        // read data taken
  input  wire logic          regMoveActive, // current access is a reg-to-reg move
  input  wire logic [W-1:0]  pinInB,        // port b pin levels
  output logic [W-1:0]       pinOutB,       // port b drive value
  output logic [W-1:0]       pinOeB,        // port b drive enable
  output logic [W-1:0]       pullUpB,       // port b weak pull-up on
  input  wire logic [W-1:0]  pinInC,        // port c pin levels
  output logic [W-1:0]       pinOutC,       // port c drive value
  output logic [W-1:0]       pinOeC,        // port c drive enable
  input  wire logic [W-1:0]  periphEnC,     // peripheral owns port c pin
  input  wire logic [W-1:0]  periphDirC,    // peripheral direction, 1 = input
  input  wire logic [W-1:0]  periphOutC,    // peripheral drive value
  output logic               irqHigh,       // change interrupt, high priority
  output logic               irqLow,        // change interrupt, low priority
  output logic               wakeReq        // change wake request out of sleep
);
  // register state
  logic [W-1:0] out_latch_b_ff;      // out_latch_b
  logic [W-1:0] dirB_ff;      // direction_b
  logic [W-1:0] out_latch_c_ff;      // out_latch_c
  logic [W-1:0] dirC_ff;      // direction_c
  logic         changeFlag_ff; // change_flag
  logic         chgIrqEn_ff;  // change_irq_enable
  logic         chgPrio_ff;   // change_irq_priority, 1 = high
  logic         pullDisN_ff;  // pullup_disable_n
  logic         lvp_ff;       // low_voltage_programming
  logic         wakeReq_ff;   // registered wake request
  logic         irqHigh_ff;   // registered high interrupt
  logic         irqLow_ff;    // registered low interrupt

  // bus side
  logic         wrEn;         // write taken this cycle
  logic         rdEn;         // read taken this cycle
  reg_sel_type  wrSel;        // decoded write target
  reg_sel_type  rdSel;        // decoded read target
  logic [W-1:0] wrByte;       // low data byte
  logic         wrLane0;      // low byte lane enabled
  logic [31:0]  nxt_rdata;    // read mux
  logic         nxt_rdErr;    // read of an unmapped address
  logic [W-1:0] pinMaskB;     // port b pins read through the data register
  logic         refreshB;     // port b data access, snapshot refresh
  logic         mismatch;     // change detected this cycle
  logic         flagClr;      // software writes the flag to zero
  logic [`GPIO_CHG_W-1:0] watch; // pins taking part in change detection

  gpio_port_if #(.W(W)) padB ();
  gpio_port_if #(.W(W)) padC ();

  // address decode, shared by both channels
  function automatic reg_sel_type decode(input logic [AW-1:0] addr);
    unique case (addr)
      `GPIO_OFF_PIN_B:    decode = SEL_PIN_B;
      `GPIO_OFF_LAT_B:    decode = SEL_LAT_B;
      `GPIO_OFF_DIR_B:    decode = SEL_DIR_B;
      `GPIO_OFF_PIN_C:    decode = SEL_PIN_C;
      `GPIO_OFF_LAT_C:    decode = SEL_LAT_C;
      `GPIO_OFF_DIR_C:    decode = SEL_DIR_C;
      `GPIO_OFF_IRQ_MAIN: decode = SEL_IRQ_MAIN;
      `GPIO_OFF_IRQ_EDGE: decode = SEL_IRQ_EDGE;
      `GPIO_OFF_CTRL:     decode = SEL_CTRL;
      default:            decode = SEL_NONE; // unmapped answers slverr
    endcase
  endfunction : decode

  // handshakes: a write is taken only with address and data together
  always_comb begin
    awready = awvalid & wvalid & ~bvalid;
    wready  = awvalid & wvalid & ~bvalid;
    arready = ~rvalid;
    wrEn    = awvalid & wvalid & ~bvalid;
    rdEn    = arvalid & ~rvalid;
    wrSel   = decode(awaddr);
    rdSel   = decode(araddr);
    wrByte  = wdata[W-1:0];
    wrLane0 = wstrb[0];
  end

  // port b data access refreshes the snapshot; a move bypasses it
  always_comb begin
    refreshB = ((wrEn && wrSel == SEL_PIN_B) || (rdEn && rdSel == SEL_PIN_B)) && !regMoveActive;
  end

  // bit 5 stops being general i/o while low-voltage programming is on
  always_comb begin
    pinMaskB = lvp_ff ? ~(W'(1) << `GPIO_PGM_BIT) : '1;
  end

  // port b latch: data register write and latch register write both land here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_latch_b_ff <= `GPIO_LAT_RST;
    end else if (wrEn && wrLane0 && (wrSel == SEL_PIN_B || wrSel == SEL_LAT_B)) begin
      out_latch_b_ff <= wrByte;
    end
  end

  // port b direction, all inputs out of reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirB_ff <= `GPIO_DIR_RST;
    end else if (wrEn && wrLane0 && wrSel == SEL_DIR_B) begin
      dirB_ff <= wrByte;
    end
  end

  // port c latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_latch_c_ff <= `GPIO_LAT_RST;
    end else if (wrEn && wrLane0 && (wrSel == SEL_PIN_C || wrSel == SEL_LAT_C)) begin
      out_latch_c_ff <= wrByte;
    end
  end

  // port c direction; only software writes it, overrides stay at the pad
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirC_ff <= `GPIO_DIR_RST;
    end else if (wrEn && wrLane0 && wrSel == SEL_DIR_C) begin
      dirC_ff <= wrByte;
    end
  end

  // interrupt control bits: pull-up disable resets to one so pulls start off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chgIrqEn_ff <= 1'b0;
      pullDisN_ff <= `GPIO_PULL_N_RST;
      chgPrio_ff  <= `GPIO_PRIO_RST;
      lvp_ff      <= 1'b0;
    end else if (wrEn && wrLane0) begin
      if (wrSel == SEL_IRQ_MAIN) begin
        chgIrqEn_ff <= wrByte[`GPIO_BIT_IRQ_EN];
      end
      if (wrSel == SEL_IRQ_EDGE) begin
        pullDisN_ff <= wrByte[`GPIO_BIT_PULL_N];
        chgPrio_ff  <= wrByte[`GPIO_BIT_PRIO];
      end
      if (wrSel == SEL_CTRL) begin
        lvp_ff <= wrByte[`GPIO_BIT_LVP];
      end
    end
  end

  // software clears the flag by writing zero to it
  always_comb begin
    flagClr = wrEn && wrLane0 && wrSel == SEL_IRQ_MAIN && !wrByte[`GPIO_BIT_FLAG];
  end

  // change flag: sticky; a live mismatch sets it again, so set beats clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      changeFlag_ff <= 1'b0;
    end else if (mismatch) begin
      changeFlag_ff <= 1'b1;
    end else if (flagClr) begin
      changeFlag_ff <= 1'b0;
    end
  end

  // interrupt routing and wake, enable gates both
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqHigh_ff <= 1'b0;
      irqLow_ff  <= 1'b0;
      wakeReq_ff <= 1'b0;
    end else begin
      irqHigh_ff <= changeFlag_ff & chgIrqEn_ff & chgPrio_ff;
      irqLow_ff  <= changeFlag_ff & chgIrqEn_ff & ~chgPrio_ff;
      wakeReq_ff <= changeFlag_ff & chgIrqEn_ff;
    end
  end

  // read mux: data registers show pins, latch registers show the latch
  always_comb begin
    nxt_rdata = '0;
    nxt_rdErr = 1'b0;
    unique case (rdSel)
      SEL_PIN_B:    nxt_rdata[W-1:0] = pinInB & pinMaskB;
      SEL_LAT_B:    nxt_rdata[W-1:0] = out_latch_b_ff;
      SEL_DIR_B:    nxt_rdata[W-1:0] = dirB_ff;
      SEL_PIN_C:    nxt_rdata[W-1:0] = pinInC;
      SEL_LAT_C:    nxt_rdata[W-1:0] = out_latch_c_ff;
      SEL_DIR_C:    nxt_rdata[W-1:0] = dirC_ff;
      SEL_IRQ_MAIN: begin
        nxt_rdata[`GPIO_BIT_IRQ_EN] = chgIrqEn_ff;
        nxt_rdata[`GPIO_BIT_FLAG]   = changeFlag_ff;
      end
      SEL_IRQ_EDGE: begin
        nxt_rdata[`GPIO_BIT_PULL_N] = pullDisN_ff;
        nxt_rdata[`GPIO_BIT_PRIO]   = chgPrio_ff;
      end
      SEL_CTRL:     nxt_rdata[`GPIO_BIT_LVP] = lvp_ff;
      SEL_NONE:     nxt_rdErr = 1'b1;
    endcase
  end

  // write response channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= `GPIO_RESP_OKAY;
    end else if (wrEn) begin
      bvalid <= 1'b1;
      bresp  <= (wrSel == SEL_NONE) ? `GPIO_RESP_SLVERR : `GPIO_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data channel; pins are sampled at the edge the address is taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `GPIO_RESP_OKAY;
    end else if (rdEn) begin
      rvalid <= 1'b1;
      rdata  <= nxt_rdata;
      rresp  <= nxt_rdErr ? `GPIO_RESP_SLVERR : `GPIO_RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // pad controls; bit 5 loses its pull under low-voltage programming
  always_comb begin
    padB.dirSw    = dirB_ff;
    padB.latch    = out_latch_b_ff;
    padB.ovrEn    = '0;
    padB.ovrDir   = '0;
    padB.ovrData  = '0;
    padB.pullMask = pinMaskB;
    padB.pullOn   = ~pullDisN_ff;
    padC.dirSw    = dirC_ff;
    padC.latch    = out_latch_c_ff;
    padC.ovrEn    = periphEnC;
    padC.ovrDir   = periphDirC;
    padC.ovrData  = periphOutC;
    padC.pullMask = '0;          // port c has no pull-ups
    padC.pullOn   = 1'b0;
  end

  gpio_pad_port u_pad_b (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pad     (padB.core)
  );

  gpio_pad_port u_pad_c (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pad     (padC.core)
  );

  // only upper input pins watched; bit 5 dropped while it serves programming
  always_comb begin
    watch = padB.dirEff[`GPIO_CHG_LSB +: `GPIO_CHG_W] & pinMaskB[`GPIO_CHG_LSB +: `GPIO_CHG_W];
  end

  gpio_change_detect #(.W(`GPIO_CHG_W)) u_chg (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pinIn    (pinInB[`GPIO_CHG_LSB +: `GPIO_CHG_W]),
    .watch    (watch),
    .refresh  (refreshB),
    .mismatch (mismatch)
  );

  // outputs
  always_comb begin
    pinOutB = padB.pinOut;
    pinOeB  = padB.pinOe;
    pullUpB = padB.pullEn;
    pinOutC = padC.pinOut;
    pinOeC  = padC.pinOe;
    irqHigh = irqHigh_ff;
    irqLow  = irqLow_ff;
    wakeReq = wakeReq_ff;
  end

  chk_latch_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rdEn && rdSel == SEL_LAT_B) |=> rdata[W-1:0] == $past(out_latch_b_ff))
    else $error("latch read does not return latch");
  chk_mismatch_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mismatch |=> changeFlag_ff) else $error("mismatch did not set flag");
  chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (changeFlag_ff && !flagClr) |=> changeFlag_ff) else $error("flag dropped without clear");
  chk_dir_c_untouched: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (dirC_ff != $past(dirC_ff)) |-> $past(wrEn && wrSel == SEL_DIR_C))
    else $error("direction c changed without write");
  chk_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqHigh || irqLow) |-> $past(chgIrqEn_ff && changeFlag_ff) && (irqHigh == $past(chgPrio_ff)))
    else $error("interrupt without enable or wrong priority");
  chk_lvp_pull: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lvp_ff |=> !pullUpB[`GPIO_PGM_BIT]) else $error("pull-up on programming pin");
  chk_wake_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (changeFlag_ff && chgIrqEn_ff) |=> wakeReq) else $error("no wake on change");
endmodule : gpio_bc_top
`default_nettype wire

// ### design/gpio_change_detect.sv
// change detection on the upper port b pins against the last-access snapshot
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bc_consts.svh"
module gpio_change_detect #(
  parameter int W = `GPIO_CHG_W
) (
  input  wire logic         clk_sys,  // core clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic [W-1:0] pinIn,    // upper pin levels
  input  wire logic [W-1:0] watch,    // pins taking part (inputs only)
  input  wire logic         refresh,  // port b accessed this cycle
  output logic              mismatch  // any watched pin differs
);
  logic [W-1:0] ref_ff; // snapshot taken at the last port b access

  // snapshot refresh; a reg-to-reg move never reaches here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_ff <= '0;
    end else if (refresh) begin
      ref_ff <= pinIn;
    end
  end

  // continuous compare, output pins masked, results ORed
  always_comb begin
    mismatch = |((pinIn ^ ref_ff) & watch);
  end

  chk_ref_refresh: assert property (@(posedge clk_sys) disable iff (!rst_n)
    refresh |=> ref_ff == $past(pinIn)) else $error("snapshot not taken on access");
endmodule : gpio_change_detect
`default_nettype wire

// ### design/gpio_pad_port.sv
// pad side of one port: direction, drive value and weak pull-up
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_port (
  input wire logic    clk_sys, // core clock
  input wire logic    rst_n,   // async reset, active low
  gpio_port_if.core   pad      // controls in, pad drive out
);
  // effective direction: a peripheral wins over software, register untouched
  always_comb begin
    pad.dirEff = (pad.ovrEn & pad.ovrDir) | (~pad.ovrEn & pad.dirSw);
  end

  // registered pad drive; reset leaves every pin an input with no pull
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pad.pinOe  <= '0;
      pad.pinOut <= '0;
      pad.pullEn <= '0;
    end else begin
      pad.pinOe  <= ~pad.dirEff;
      pad.pinOut <= (pad.ovrEn & ~pad.ovrDir & pad.ovrData) | (~(pad.ovrEn & ~pad.ovrDir) & pad.latch);
      // pull only on input pins, so an output never fights its own pull
      pad.pullEn <= {$bits(pad.pullEn){pad.pullOn}} & pad.dirEff & pad.pullMask;
    end
  end

  chk_dir_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 pad.pinOe == ~$past(pad.dirEff)) else $error("pad enable does not follow direction");
  chk_pull_output_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 (pad.pullEn & ~$past(pad.dirEff)) == '0) else $error("pull-up on an output pin");
endmodule : gpio_pad_port
`default_nettype wire

// ### design/gpio_port_if.sv
// carrier between the register core and one port's pad logic
`timescale 1ns/1ps
`default_nettype none
interface gpio_port_if #(parameter int W = 8);
  logic [W-1:0] dirSw;    // software direction, 1 = input
  logic [W-1:0] latch;    // output latch
  logic [W-1:0] ovrEn;    // peripheral owns direction
  logic [W-1:0] ovrDir;   // peripheral direction, 1 = input
  logic [W-1:0] ovrData;  // peripheral drive value
  logic [W-1:0] pullMask; // pins allowed a pull-up
  logic         pullOn;   // global pull-up request
  logic [W-1:0] dirEff;   // direction seen at the pad
  logic [W-1:0] pinOut;   // pad drive value
  logic [W-1:0] pinOe;    // pad drive enable
  logic [W-1:0] pullEn;   // weak pull-up on
  modport core (input dirSw, latch, ovrEn, ovrDir, ovrData, pullMask, pullOn,
                output dirEff, pinOut, pinOe, pullEn);
  modport ctl  (output dirSw, latch, ovrEn, ovrDir, ovrData, pullMask, pullOn,
                input dirEff, pinOut, pinOe, pullEn);
endinterface : gpio_port_if
`default_nettype wire

// ### testbench/gpio_bc_top_test.sv
// self-checking bench of the port b/c block over axi4-lite
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bc_consts.svh"
module gpio_bc_top_test;
  logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, regMoveActive; // bus and control
  logic awready, wready, bvalid, arready, rvalid, irqHigh, irqLow, wakeReq;       // design answers
  logic [7:0] awaddr, araddr, pinInB, pinInC, pinOutB, pinOeB, pullUpB, pinOutC, pinOeC; // addresses, pads
  logic [7:0] periphEnC, periphDirC, periphOutC, extEnB, extValB, extEnC, extValC; // outside drivers
  logic [31:0] wdata, rdata, rd_d; // bus data
  logic [3:0] wstrb;               // byte enables
  logic [3:0] strb = 4'hF;         // byte enables the next write offers
  logic [1:0] bresp, rresp, rd_r;  // responses
  int error_cnt = 0;               // mismatches seen
  int checked = 0;                 // comparisons made
  gpio_bc_top i_gpio_bc_top (.clk_sys(clk_sys), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .regMoveActive(regMoveActive), .pinInB(pinInB),
    .pinOutB(pinOutB), .pinOeB(pinOeB), .pullUpB(pullUpB), .pinInC(pinInC), .pinOutC(pinOutC),
    .pinOeC(pinOeC), .periphEnC(periphEnC), .periphDirC(periphDirC), .periphOutC(periphOutC),
    .irqHigh(irqHigh), .irqLow(irqLow), .wakeReq(wakeReq));
  gpio_pin_model i_gpio_pin_model_b (.clk_sys(clk_sys), .pinOe(pinOeB), .pinOut(pinOutB), .pullUp(pullUpB),
    .extEn(extEnB), .extVal(extValB), .pinIn(pinInB));
  // port c has no pull-ups, so its model sees none
  gpio_pin_model i_gpio_pin_model_c (.clk_sys(clk_sys), .pinOe(pinOeC), .pinOut(pinOutC), .pullUp(8'h00),
    .extEn(extEnC), .extVal(extValC), .pinIn(pinInC));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    $display("counts: %0d comparisons, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
    chk_word({24'h0000_00, got}, {24'h0000_00, exp});
  endtask : chk_pins
  // let n edges pass; a read at the edge sees what settled before it, so stimulus stays on the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // one write: both channels offered together, held until taken, then the response
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a; wdata <= {24'h0000_00, d}; wstrb <= strb; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (!(awready === 1'b1 && wready === 1'b1) && n < 50);
    awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) error_cnt++;
    chk_word({30'h0, bresp}, {30'h0, `GPIO_RESP_OKAY});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (arready !== 1'b1 && n < 50);
    // raising rready only here keeps back-to-back reads from driving it twice in one step
    arvalid <= 1'b0; rready <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (rvalid !== 1'b1 && n < 50);
    rd_d = rdata; rd_r = rresp; rready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk_word(rd_d, {24'h0000_00, e});
    chk_word({30'h0, rd_r}, {30'h0, `GPIO_RESP_OKAY});
  endtask : rdc
  task automatic t_reset;
    rdc(`GPIO_OFF_DIR_B, 8'hFF);
    rdc(`GPIO_OFF_DIR_C, 8'hFF);
    rdc(`GPIO_OFF_IRQ_EDGE, 8'h81);
    chk_pins(pullUpB, 8'h00);
    rd(8'h24);
    chk_word({30'h0, rd_r}, {30'h0, `GPIO_RESP_SLVERR});
    $display("test reset done");
  endtask : t_reset
  task automatic t_port_b;
    wr(`GPIO_OFF_LAT_B, 8'hA5); wr(`GPIO_OFF_DIR_B, 8'h0F); cyc(2);
    chk_pins(pinOeB, 8'hF0);
    chk_pins(pinOutB & pinOeB, 8'hA0);
    extEnB <= 8'h0F; extValB <= 8'h03; cyc(1);
    rdc(`GPIO_OFF_PIN_B, 8'hA3);
    rdc(`GPIO_OFF_LAT_B, 8'hA5);
    wr(`GPIO_OFF_IRQ_EDGE, 8'h01); cyc(2);
    chk_pins(pullUpB, 8'h0F);
    wr(`GPIO_OFF_PIN_B, 8'h5A);
    rdc(`GPIO_OFF_LAT_B, 8'h5A);
    wr(`GPIO_OFF_IRQ_EDGE, 8'h81); wr(`GPIO_OFF_DIR_B, 8'hFF);
    $display("test port b done");
  endtask : t_port_b
  task automatic t_port_c;
    wr(`GPIO_OFF_DIR_C, 8'h00); wr(`GPIO_OFF_LAT_C, 8'h3C); cyc(2);
    chk_pins(pinOeC, 8'hFF);
    chk_pins(pinOutC, 8'h3C);
    periphEnC <= 8'h03; periphDirC <= 8'h01; periphOutC <= 8'h02; cyc(2);
    chk_pins(pinOeC, 8'hFE);
    chk_pins(pinOutC & pinOeC, 8'h3E);
    rdc(`GPIO_OFF_DIR_C, 8'h00);
    rdc(`GPIO_OFF_LAT_C, 8'h3C);
    rdc(`GPIO_OFF_PIN_C, 8'h3F);
    strb = 4'hE; wr(`GPIO_OFF_LAT_C, 8'hFF); strb = 4'hF;
    rdc(`GPIO_OFF_LAT_C, 8'h3C);
    $display("test port c done");
  endtask : t_port_c
  task automatic t_change;
    extEnB <= 8'hFF; extValB <= 8'h00; cyc(1);
    rd(`GPIO_OFF_PIN_B); wr(`GPIO_OFF_IRQ_MAIN, 8'h08);
    extValB <= 8'h01; cyc(3);
    rdc(`GPIO_OFF_IRQ_MAIN, 8'h08);
    extValB <= 8'h11; cyc(3);
    rdc(`GPIO_OFF_IRQ_MAIN, 8'h09);
    chk_pins({wakeReq, irqHigh, irqLow, 5'h00}, 8'hC0);
    wr(`GPIO_OFF_IRQ_MAIN, 8'h08);
    rdc(`GPIO_OFF_IRQ_MAIN, 8'h09);
    regMoveActive <= 1'b1; rd(`GPIO_OFF_PIN_B); regMoveActive <= 1'b0;
    wr(`GPIO_OFF_IRQ_MAIN, 8'h08);
    rdc(`GPIO_OFF_IRQ_MAIN, 8'h09);
    rd(`GPIO_OFF_PIN_B); cyc(2);
    rdc(`GPIO_OFF_IRQ_MAIN, 8'h09);
    wr(`GPIO_OFF_IRQ_MAIN, 8'h08);
    rdc(`GPIO_OFF_IRQ_MAIN, 8'h08);
    wr(`GPIO_OFF_IRQ_EDGE, 8'h80); extValB <= 8'h91; cyc(3);
    chk_pins({wakeReq, irqHigh, irqLow, 5'h00}, 8'hA0);
    rd(`GPIO_OFF_PIN_B); wr(`GPIO_OFF_IRQ_MAIN, 8'h08);
    wr(`GPIO_OFF_DIR_B, 8'h7F); cyc(3);
    rdc(`GPIO_OFF_IRQ_MAIN, 8'h08);
    $display("test change done");
  endtask : t_change
  task automatic t_lvp;
    wr(`GPIO_OFF_DIR_B, 8'hFF); wr(`GPIO_OFF_CTRL, 8'h01); wr(`GPIO_OFF_IRQ_EDGE, 8'h01); cyc(2);
    chk_pins(pullUpB, 8'hDF);
    extValB <= 8'h20; cyc(1);
    rdc(`GPIO_OFF_PIN_B, 8'h00);
    // software side of programming mode: latch bit 5 cleared before bit 5 turns output
    wr(`GPIO_OFF_LAT_B, 8'h00); wr(`GPIO_OFF_DIR_B, 8'hDF); cyc(2);
    chk_pins(pinOeB, 8'h20);
    chk_pins(pinOutB & pinOeB, 8'h00);
    $display("test low voltage programming done");
  endtask : t_lvp
  // main sequence: inputs at time zero, two reset cycles, then the tests
  initial begin
    rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h0; regMoveActive = 1'b0;
    periphEnC = 8'h00; periphDirC = 8'h00; periphOutC = 8'h00;
    extEnB = 8'hFF; extValB = 8'h00; extEnC = 8'hFF; extValC = 8'h55;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(1);
    t_reset; t_port_b; t_port_c; t_change; t_lvp;
    report_and_stop;
  end
  // watchdog: the whole sequence needs about 120 cycles
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
endmodule : gpio_bc_top_test
`default_nettype wire

// ### testbench/gpio_pin_model.sv
// behavioural model of the pins and loads outside one port
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model (
  input  wire logic       clk_sys, // core clock
  input  wire logic [7:0] pinOe,   // device drives the pin
  input  wire logic [7:0] pinOut,  // device drive value
  input  wire logic [7:0] pullUp,  // device weak pull-up on
  input  wire logic [7:0] extEn,   // outside source drives the pin
  input  wire logic [7:0] extVal,  // outside source value
  output logic      [7:0] pinIn    // level seen back at the device
);
  logic [7:0] float_ff = 8'h55; // open pins wander, so no guess passes as a level
  // toggle each cycle: a read of an open pin can not match by luck twice
  always @(posedge clk_sys) float_ff <= ~float_ff;
  // device drive wins, then a strong outside source, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] : pullUp[i] ? 1'b1 : float_ff[i];
    end
  end
endmodule : gpio_pin_model
`default_nettype wire
